// ---- core/mrs_bank.sv ----
// mode-register bank: temperature status, identity, test and calibration
`timescale 1ns/100ps
`include "mrs_cfg.svh"

// Functional notes
// R1 - reading the temperature status register clears its update flag
// R2 - update flag is zero after power-up
// R3 - flag sets when refresh-rate field changes after last read
// R4 - refresh-rate field bit 2 set means die hotter than 85C
// R5 - controller treats rate codes 000 and 111 as unsafe
// R6 - controller adds 1.875ns to core timings when derating; the model only sets derate_q for rate code 110 and changes no timing
// R7 - address 05h returns the read-only maker code
// R8 - addresses 06h and 07h return read-only revision codes
// R9 - address 08h bits 1:0 give device type, 00 four-bit prefetch
// R10 - address 08h bits 5:2 give density, 0101 for 2Gb
// R11 - address 08h bits 7:6 give I/O width, 00 x32, 01 x16
// R12 - address 09h is vendor test mode, untouched in normal use
// R13 - code FF starts post-init calibration, C3 resets calibration
// R14 - code AB starts long, 56 short calibration at 0Ah
// R15 - controller never writes reserved calibration codes; the bench sends 00h and 12h to 0Ah through the model
// R16 - reserved calibration codes are ignored
// R17 - refresh code 010 is twice, 011 once nominal interval
// R18 - writes to read-only registers leave their values unchanged
module mrs_bank
    import mrs_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = `MRS_MAKER_CODE, // arbitrary value
    parameter logic [7:0] REV1_CODE = `MRS_REV1_CODE, // arbitrary value
    parameter logic [7:0] REV2_CODE = `MRS_REV2_CODE, // arbitrary value
    parameter logic [1:0] IO_WIDTH = `MRS_IOW_X32
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic mr_rd_in,
    input wire logic mr_wr_in,
    input wire logic [7:0] mode_reg_address_in,
    input wire logic [7:0] mr_wdata_in,
    input wire logic [2:0] refresh_rate_field_in,
    output logic [7:0] mr_rdata_out,
    output logic mr_rvalid_out,
    output logic temp_change_flag_out,
    output logic over_85c_out,
    output logic [2:0] cal_cmd_out,
    output logic cal_start_out
);
    logic [2:0] rate_s1_q, rate_s2_q, rate_d, rate_q;
    logic flag_q, flag_d;
    logic [7:0] test_q, test_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [2:0] calcmd_q, calcmd_d;
    logic calst_q, calst_d;
    logic rd_temp;

    mrs_cal_if cal ();

    // ----------------------------------------------------------------
    // read mux function
    // ----------------------------------------------------------------
    function automatic logic [7:0] mrs_read(input logic [7:0] addr, input logic flag,
                                            input logic [2:0] rate, input logic [7:0] test);
        logic [7:0] val;
        val = 8'h00;
        case (addr)
            `MRS_ADDR_TEMP: val = {flag, 4'h0, rate};
            `MRS_ADDR_MAKER: val = MAKER_CODE; // R7
            `MRS_ADDR_REV1: val = REV1_CODE; // R8
            `MRS_ADDR_REV2: val = REV2_CODE; // R8
            `MRS_ADDR_CONF: val = {IO_WIDTH, `MRS_DENS_2GB, `MRS_TYPE_PREFETCH4}; // R9 R10 R11
            `MRS_ADDR_TEST: val = test; // R12
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // ----------------------------------------------------------------
    // sensor input synchroniser
    // ----------------------------------------------------------------
    // sensor code comes from an analog block; two stages before use
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rate_s1_q <= `MRS_RATE_RESET;
            rate_s2_q <= `MRS_RATE_RESET;
        end else begin
            rate_s1_q <= refresh_rate_field_in;
            rate_s2_q <= rate_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // temperature status
    // ----------------------------------------------------------------
    assign rd_temp = mr_rd_in && (mode_reg_address_in == `MRS_ADDR_TEMP);

    // change sets the flag, a read clears it; a change in the read cycle wins
    always_comb begin
        rate_d = rate_s2_q; // R17
        flag_d = flag_q;
        if (rd_temp) begin
            flag_d = 1'b0; // R1
        end
        if (rate_s2_q != rate_q) begin
            flag_d = 1'b1; // R3
        end
    end

    // flag and latched rate registers
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rate_q <= `MRS_RATE_RESET;
            flag_q <= 1'b0; // R2
        end else begin
            rate_q <= rate_d;
            flag_q <= flag_d;
        end
    end

    // ----------------------------------------------------------------
    // register writes and reads
    // ----------------------------------------------------------------
    // only test and calibration addresses accept writes
    always_comb begin
        test_d = test_q;
        if (mr_wr_in && mode_reg_address_in == `MRS_ADDR_TEST) begin
            test_d = mr_wdata_in; // R12
        end
        // identity and config addresses have no write path
        rdata_d = rdata_q; // R18
        rvalid_d = mr_rd_in;
        if (mr_rd_in) begin
            rdata_d = mrs_read(mode_reg_address_in, flag_q, rate_q, test_q);
        end
    end

    // write-side and read-data registers
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            test_q <= `MRS_TEST_RESET;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            test_q <= test_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ----------------------------------------------------------------
    // calibration command
    // ----------------------------------------------------------------
    assign cal.wr_stb = mr_wr_in && (mode_reg_address_in == `MRS_ADDR_CAL);
    assign cal.code = mr_wdata_in;

    mrs_cal_dec u_cal_dec (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .cal(cal)
    );

    // retime decoder output onto top-level flops
    always_comb begin
        calcmd_d = cal.cmd;
        calst_d = cal.cmd_vld; // R13 R14
    end

    // calibration output registers
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            calcmd_q <= 3'h0;
            calst_q <= 1'b0;
        end else begin
            calcmd_q <= calcmd_d;
            calst_q <= calst_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign mr_rdata_out = rdata_q;
    assign mr_rvalid_out = rvalid_q;
    assign temp_change_flag_out = flag_q;
    assign over_85c_out = rate_q[`MRS_HOT_BIT]; // R4
    assign cal_cmd_out = calcmd_q;
    assign cal_start_out = calst_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_FLAG_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R1
        rd_temp && rate_s2_q == rate_q |=> !temp_change_flag_out)
        else $error("temperature read did not clear flag");
    AST_FLAG_RESET: assert property (@(posedge clk_in) // R2
        !rst_b_in |=> !temp_change_flag_out)
        else $error("flag not zero after reset");
    AST_FLAG_SET: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R3
        $changed(rate_q) |-> temp_change_flag_out)
        else $error("rate change did not set flag");
    AST_HOT: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R4
        over_85c_out == rate_q[2])
        else $error("hot indication mismatched");
    AST_MAKER: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R7
        mr_rd_in && mode_reg_address_in == 8'h05 |=> mr_rvalid_out && mr_rdata_out == MAKER_CODE)
        else $error("maker code wrong");
    AST_REV: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R8
        mr_rd_in && mode_reg_address_in == 8'h07 |=> mr_rdata_out == REV2_CODE)
        else $error("revision code wrong");
    AST_CONF: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R10
        mr_rd_in && mode_reg_address_in == 8'h08 |=> mr_rdata_out[5:0] == 6'h14)
        else $error("type or density wrong");
    AST_CAL_START: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R13
        mr_wr_in && mode_reg_address_in == 8'h0A && mr_wdata_in == 8'hC3
        |=> ##1 cal_start_out && cal_cmd_out == 3'h4)
        else $error("calibration reset not issued after two cycles");
    AST_RO_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R18
        mr_wr_in && mode_reg_address_in == 8'h05 ##[1:8] mr_rd_in && mode_reg_address_in == 8'h05
        |=> mr_rdata_out == MAKER_CODE)
        else $error("write altered read-only register");
    COV_FLAG: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        temp_change_flag_out ##1 rd_temp ##1 !temp_change_flag_out);
    COV_CAL: cover property (@(posedge clk_in) disable iff (!rst_b_in) cal_start_out);
    COV_RACE: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        rd_temp && rate_s2_q != rate_q);
endmodule

// ---- core/mrs_cfg.svh ----
// mode-register bank addresses, field positions and fixed codes
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
`define MRS_ADDR_TEMP 8'h04
`define MRS_ADDR_MAKER 8'h05
`define MRS_ADDR_REV1 8'h06
`define MRS_ADDR_REV2 8'h07
`define MRS_ADDR_CONF 8'h08
`define MRS_ADDR_TEST 8'h09
`define MRS_ADDR_CAL 8'h0A
`define MRS_FLAG_BIT 7
`define MRS_HOT_BIT 2
`define MRS_CAL_INIT 8'hFF
`define MRS_CAL_LONG 8'hAB
`define MRS_CAL_SHORT 8'h56
`define MRS_CAL_RESET 8'hC3
`define MRS_TYPE_PREFETCH4 2'h0
`define MRS_DENS_2GB 4'h5
`define MRS_IOW_X32 2'h0
`define MRS_IOW_X16 2'h1
`define MRS_RATE_RESET 3'h3
`define MRS_RATE_2X 3'h2
`define MRS_RATE_1X 3'h3
`define MRS_TEST_RESET 8'h00
`define MRS_MAKER_CODE 8'h5A
`define MRS_REV1_CODE 8'h11
`define MRS_REV2_CODE 8'h22
`endif

// ---- core/mrs_pkg.sv ----
// types shared by the mode-register bank
package mrs_pkg;
    typedef enum logic [2:0] {
        MRS_CAL_NONE,
        MRS_CAL_INIT_C,
        MRS_CAL_LONG_C,
        MRS_CAL_SHORT_C,
        MRS_CAL_RESET_C
    } mrs_cal_t;
endpackage

// ---- core/mrs_cal_if.sv ----
// carrier between the bank and its calibration decoder
`timescale 1ns/100ps
interface mrs_cal_if;
    logic wr_stb;
    logic [7:0] code;
    mrs_pkg::mrs_cal_t cmd;
    logic cmd_vld;
    modport bank (output wr_stb, output code, input cmd, input cmd_vld);
    modport dec (input wr_stb, input code, output cmd, output cmd_vld);
endinterface

// ---- core/mrs_cal_dec.sv ----
// calibration command decoder with registered one-cycle outputs
`timescale 1ns/100ps
`include "mrs_cfg.svh"
module mrs_cal_dec
    import mrs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    mrs_cal_if.dec cal
);
    mrs_cal_t cmd_q, cmd_d;
    logic vld_q, vld_d;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // reserved codes yield no command at all
    always_comb begin
        cmd_d = MRS_CAL_NONE;
        vld_d = 1'b0;
        if (cal.wr_stb) begin
            vld_d = 1'b1;
            case (cal.code)
                `MRS_CAL_INIT: cmd_d = MRS_CAL_INIT_C; // R13
                `MRS_CAL_RESET: cmd_d = MRS_CAL_RESET_C; // R13
                `MRS_CAL_LONG: cmd_d = MRS_CAL_LONG_C; // R14
                `MRS_CAL_SHORT: cmd_d = MRS_CAL_SHORT_C; // R14
                default: vld_d = 1'b0; // R16
            endcase
        end
    end

    // register decode result
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cmd_q <= MRS_CAL_NONE;
            vld_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            vld_q <= vld_d;
        end
    end

    assign cal.cmd = cmd_q;
    assign cal.cmd_vld = vld_q;

    AST_CAL_RSVD: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R16
        cal.wr_stb && !(cal.code inside {8'hFF, 8'hAB, 8'h56, 8'hC3}) |=> !cal.cmd_vld)
        else $error("reserved calibration code produced a command");
    AST_CAL_LONG: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R14
        cal.wr_stb && cal.code == 8'hAB |=> cal.cmd_vld && cal.cmd == MRS_CAL_LONG_C)
        else $error("long calibration not issued");
endmodule

// ---- sim/mrs_ctrl_model.sv ----
// memory-controller model issuing mode-register reads and writes
`timescale 1ns/100ps
module mrs_ctrl_model (
    input wire logic clk_in,
    input wire logic [7:0] mr_rdata_in,
    input wire logic mr_rvalid_in,
    input wire logic [2:0] cal_cmd_in,
    input wire logic cal_start_in,
    output logic mr_rd_out,
    output logic mr_wr_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    logic derate_q; // set for rate code 110; no core timing is stretched
    logic unsafe_q; // rate code where operation is not assured
    // idle bus at time zero
    initial begin
        mr_rd_out = 1'b0;
        mr_wr_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
        derate_q = 1'b0;
        unsafe_q = 1'b0;
    end
    // one read; released lines show the inverse so no stale value passes
    task automatic mr_read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_in);
        mr_rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        mr_rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        v = mr_rvalid_in;
        d = mr_rdata_in;
        if (a == 8'h04) begin
            derate_q = (d[2:0] == 3'h6);
            unsafe_q = (d[2:0] == 3'h0) || (d[2:0] == 3'h7);
        end
    endtask
    // one write; reserved calibration codes only when a scenario asks
    task automatic mr_write(input logic [7:0] a, input logic [7:0] d,
                            output logic s, output logic [2:0] c);
        @(posedge clk_in);
        mr_wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        mr_wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
        // start pulse stands in the second cycle after the write is taken
        @(posedge clk_in);
        #1;
        s = cal_start_in;
        c = cal_cmd_in;
    endtask
endmodule

// ---- sim/sdram_mode_register_status_tb_top.sv ----
// self-checking bench for the mode-register bank
`timescale 1ns/100ps
`include "mrs_cfg.svh"
`define CHK(act, exp) begin \
    check_count++; \
    if ((act) !== (exp)) begin \
        num_errors++; \
        $display("wrong value at %0t: got %h exp %h", $time, (act), (exp)); \
    end \
end
module sdram_mode_register_status_tb_top;
    logic clk_in, rst_b_in, rd, wr, rvalid, flag, hot, cal_start, vld, st;
    logic [7:0] addr, wdata, rdata, got;
    logic [2:0] rate, cal_cmd, cmd;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] cal_code [6] = '{8'hFF, 8'hAB, 8'h56, 8'hC3, 8'h00, 8'h12};
    logic [2:0] cal_exp [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
    logic [2:0] rates [4] = '{3'h6, 3'h2, 3'h5, 3'h3};
    logic [7:0] ids [4] = '{`MRS_MAKER_CODE, `MRS_REV1_CODE, `MRS_REV2_CODE,
                            {`MRS_IOW_X32, `MRS_DENS_2GB, `MRS_TYPE_PREFETCH4}};

    mrs_bank mrs_bank_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .mr_rd_in(rd),
        .mr_wr_in(wr), .mode_reg_address_in(addr), .mr_wdata_in(wdata),
        .refresh_rate_field_in(rate), .mr_rdata_out(rdata), .mr_rvalid_out(rvalid),
        .temp_change_flag_out(flag), .over_85c_out(hot), .cal_cmd_out(cal_cmd),
        .cal_start_out(cal_start));
    mrs_ctrl_model mrs_ctrl_model_inst (.clk_in(clk_in), .mr_rdata_in(rdata),
        .mr_rvalid_in(rvalid), .cal_cmd_in(cal_cmd), .cal_start_in(cal_start),
        .mr_rd_out(rd), .mr_wr_out(wr), .addr_out(addr), .wdata_out(wdata));

    // verdict and end of run
    task automatic test_done();
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // 25 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end
    // main sequence
    initial begin
        rst_b_in = 1'b0;
        rate = `MRS_RATE_RESET;
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        #1;
        `CHK(flag, 1'b0)
        mrs_ctrl_model_inst.mr_read(8'h04, got, vld);
        `CHK({vld, got}, {1'b1, 5'h00, `MRS_RATE_RESET})
        // sensor changes raise the flag; a read returns and clears it
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            rate <= rates[i];
            repeat (5) @(posedge clk_in);
            #1;
            `CHK({flag, hot}, {1'b1, rates[i][2]})
            mrs_ctrl_model_inst.mr_read(8'h04, got, vld);
            `CHK({flag, got}, {1'b0, 5'h10, rates[i]})
        end
        mrs_ctrl_model_inst.mr_read(8'h04, got, vld);
        `CHK(got, {5'h00, `MRS_RATE_1X})
        // identity and configuration, before and after a write attempt
        for (int i = 0; i < 4; i++) begin
            mrs_ctrl_model_inst.mr_read(8'h05 + 8'(i), got, vld);
            `CHK(got, ids[i])
            mrs_ctrl_model_inst.mr_write(8'h05 + 8'(i), ~ids[i], st, cmd);
            mrs_ctrl_model_inst.mr_read(8'h05 + 8'(i), got, vld);
            `CHK({st, got}, {1'b0, ids[i]})
        end
        mrs_ctrl_model_inst.mr_write(8'h09, 8'hA5, st, cmd);
        mrs_ctrl_model_inst.mr_read(8'h09, got, vld);
        `CHK(got, 8'hA5)
        mrs_ctrl_model_inst.mr_read(8'h30, got, vld);
        `CHK({vld, got}, 9'h100)
        // calibration codes, documented and reserved
        for (int i = 0; i < 6; i++) begin
            mrs_ctrl_model_inst.mr_write(8'h0A, cal_code[i], st, cmd);
            `CHK(st, (i < 4))
            if (i < 4) begin
                `CHK(cmd, cal_exp[i])
            end
        end
        test_done();
    end
endmodule
